// file: core/ddrt_pkg.sv
// Shared constants, field layouts and command codes for the timing pair
package ddrt_pkg;
	// ************************************************************
	// Clock and documented times
	// ************************************************************
	localparam real CK_NS = 5.0;
	localparam real EPS = 0.001;
	localparam real T_RFC_NS = 160.0;
	localparam real T_REFI_NORM_US = 7.8;
	localparam real T_REFI_HOT_US = 3.9;
	localparam real T_AOFPD_MAX_NS = 8.5;
	localparam real T_XPDLL_NS = 24.0;
	// Least times round up, longest times round down, never below one
	localparam logic [7:0] RFC_CYC = 8'($ceil(T_RFC_NS / CK_NS - EPS));
	localparam logic [10:0] REFI_NORM_CYC =
		11'($floor(T_REFI_NORM_US * 1000.0 / CK_NS + EPS));
	localparam logic [10:0] REFI_HOT_CYC =
		11'($floor(T_REFI_HOT_US * 1000.0 / CK_NS + EPS));
	localparam int ASYNC_FL = int'($floor(T_AOFPD_MAX_NS / CK_NS + EPS));
	localparam int ASYNC_CYC = (ASYNC_FL < 1) ? 1 : ASYNC_FL;
	localparam int XPDLL_NS_CYC = int'($ceil(T_XPDLL_NS / CK_NS - EPS));
	localparam logic [7:0] XPDLL_CYC = 8'((XPDLL_NS_CYC > 10) ?
		XPDLL_NS_CYC : 10);
	localparam logic [7:0] MOD_CYC = 8'h0C;
	localparam logic [7:0] REFPDEN_CYC = 8'h01;
	localparam logic [7:0] WRA_EXTRA = 8'h01;
	localparam logic [7:0] TAIL_BL8 = 8'h04;
	localparam logic [7:0] TAIL_BC4 = 8'h02;
	localparam logic [7:0] ODTH_SHORT = 8'h04;
	localparam logic [7:0] ODTH_LONG = 8'h06;
	localparam logic [7:0] LVL_STROBE_CYC = 8'h28;
	localparam logic [7:0] LVL_ENABLE_CYC = 8'h19;
	localparam logic [4:0] TERM_LAT_SUB = 5'h02;
	// ************************************************************
	// Mode-register fields on the link address
	// ************************************************************
	localparam int MA_CWL = 0;
	localparam int MA_AL = 4;
	localparam int MA_WR = 8;
	localparam int MA_BC4 = 12;
	localparam int MA_LVL = 13;
	localparam int MA_DLLFZ = 14;
	// ************************************************************
	// Controller registers
	// ************************************************************
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_CFG = 8'h04;
	localparam logic [7:0] A_CTRL = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam int CF_CWL = 0;
	localparam int CF_AL = 4;
	localparam int CF_WRNS = 8;
	localparam int CF_BC4 = 16;
	localparam int CF_HOT = 17;
	localparam int CF_DLLFZ = 18;
	localparam int CF_AUTO = 19;
	localparam logic [31:0] CFG_RST = 32'h0000_0F05;
	typedef enum logic [2:0] {
		C_NOP = 3'h0, C_ACT = 3'h1, C_REF = 3'h2, C_MRS = 3'h3,
		C_WR = 3'h4, C_WRA = 3'h5, C_RD = 3'h6, C_PRE = 3'h7
	} ddrt_cmd_t;
	typedef enum logic [1:0] {PW_UP = 2'b01, PW_DOWN = 2'b10} ddrt_pwr_t;
endpackage

// file: core/ddrt_if.sv
// Link between the memory controller end and the memory device end
`timescale 1ns/1ps
interface ddrt_if;
	import ddrt_pkg::*;
	logic cke;
	ddrt_cmd_t cmd;
	logic [15:0] addr;
	logic bc4_otf;
	logic odt;
	logic dqs_oe;
	logic dqs;
	modport dev (input cke, cmd, addr, bc4_otf, odt, dqs_oe, dqs);
	modport ctl (output cke, cmd, addr, bc4_otf, odt, dqs_oe, dqs);
endinterface

// file: core/ddrt_dev.sv
// Memory device end: termination latency, write start, power-down
`timescale 1ns/1ps
module ddrt_dev import ddrt_pkg::*; (
	input wire logic CLK,
	input wire logic NRST,
	ddrt_if.dev L,
	output logic TERM_NOM,
	output logic TERM_WR,
	output logic WR_START,
	output logic PD_IDLE
);
	// ************************************************************
	// Mode state and decode
	// ************************************************************
	logic [3:0] cwl_reg, al_reg, wrc_reg;
	logic bc4f_reg, dllfz_reg;
	logic [63:0] odt_sr, wr_sr;
	logic [3:0] async_sr;
	logic [7:0] win_cnt, rfc_cnt, ap_cnt;
	logic row_reg, tnom_reg, twr_reg, wst_reg, pdi_reg;
	logic [4:0] wl;
	logic [5:0] term_idx, start_idx;
	logic take, is_wr, frozen, term_sel, wr_act;
	logic [7:0] ap_load;

	// Commands count only while clock enable is high
	assign take = L.cke;
	assign is_wr = take && (L.cmd == C_WR || L.cmd == C_WRA);
	assign wl = 5'({1'b0, cwl_reg} + {1'b0, al_reg});
	assign term_idx = {1'b0, 5'(wl - TERM_LAT_SUB - 5'h01)};
	// Fixed chop starts the internal write two cycles early; on-the-fly chop does not
	assign start_idx = 6'({1'b0, wl} + (bc4f_reg ? 6'h01 : 6'h03));
	assign frozen = !L.cke && dllfz_reg;
	// Frozen loop: plain delay path, no latency pipe
	assign term_sel = frozen ? async_sr[ASYNC_CYC-1] : odt_sr[term_idx];
	assign wr_act = (win_cnt != 8'h00) || wr_sr[term_idx];
	assign ap_load = 8'(wl) + TAIL_BL8 + 8'(wrc_reg) + WRA_EXTRA;

	// Mode register capture
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			cwl_reg <= 4'h5;
			al_reg <= 4'h0;
			wrc_reg <= 4'h5;
			bc4f_reg <= 1'b0;
			dllfz_reg <= 1'b0;
		end else if (take && L.cmd == C_MRS) begin
			cwl_reg <= L.addr[MA_CWL +: 4];
			al_reg <= L.addr[MA_AL +: 4];
			wrc_reg <= L.addr[MA_WR +: 4];
			bc4f_reg <= L.addr[MA_BC4];
			dllfz_reg <= L.addr[MA_DLLFZ];
		end
	end

	// ************************************************************
	// Termination and write pipes
	// ************************************************************
	// Sub-cycle windows collapse onto the next edge at this clock rate
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			odt_sr <= 64'h0000_0000_0000_0000;
			wr_sr <= 64'h0000_0000_0000_0000;
			async_sr <= 4'h0;
			win_cnt <= 8'h00;
			tnom_reg <= 1'b0;
			twr_reg <= 1'b0;
			wst_reg <= 1'b0;
		end else begin
			odt_sr <= {odt_sr[62:0], L.odt};
			wr_sr <= {wr_sr[62:0], is_wr};
			async_sr <= {async_sr[2:0], L.odt};
			if (wr_sr[term_idx])
				win_cnt <= bc4f_reg ? ODTH_SHORT : ODTH_LONG;
			else if (win_cnt != 8'h00)
				win_cnt <= win_cnt - 8'h01;
			tnom_reg <= term_sel && !wr_act;
			twr_reg <= term_sel && wr_act;
			wst_reg <= wr_sr[start_idx];
		end
	end

	// ************************************************************
	// Busy tracking for power-down current
	// ************************************************************
	// Late clock-enable low is allowed; idle shows only once done
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			rfc_cnt <= 8'h00;
			ap_cnt <= 8'h00;
			row_reg <= 1'b0;
			pdi_reg <= 1'b0;
		end else begin
			if (take && L.cmd == C_REF)
				rfc_cnt <= RFC_CYC;
			else if (rfc_cnt != 8'h00)
				rfc_cnt <= rfc_cnt - 8'h01;
			if (take && L.cmd == C_WRA)
				ap_cnt <= ap_load;
			else if (ap_cnt != 8'h00)
				ap_cnt <= ap_cnt - 8'h01;
			row_reg <= take && (L.cmd == C_ACT || L.cmd == C_PRE);
			pdi_reg <= !L.cke && rfc_cnt == 8'h00 && ap_cnt == 8'h00 &&
				!row_reg;
		end
	end

	assign TERM_NOM = tnom_reg;
	assign TERM_WR = twr_reg;
	assign WR_START = wst_reg;
	assign PD_IDLE = pdi_reg;
endmodule // ddrt_dev

// file: core/ddrt_ctl.sv
// Memory controller end: APB registers and command spacing counters
`timescale 1ns/1ps
// Behaviour
// - Fixed chop write-autoprecharge: WL+2+WR+1 before power-down
// - Refresh to power-down: one cycle
// - Mode set to power-down: mode update delay
// - Termination latency is write latency minus two
// - Termination high four cycles, no write or chop
// - Termination high six cycles with BL8 write
// - Termination off within 0.3-0.7 cycle
// - Nominal/write termination switch within 0.3-0.7 cycle
// - Frozen power-down: termination follows 2-8.5 ns
// - Leveling mode: 40 cycles before first strobe
// - Leveling mode: 25 cycles before strobe enable
// - Refresh to activate or refresh: 160 ns
// - Refresh every 7.8 us, or 3.9 us hot
// - Reads and termination need locked loop delay
// - Write recovery cycles rounded up
// - Internal write starts WL+4, or WL+2 fixed chop
// - Power-down may start during busy operations
// - Refresh-to-power-down may also need locked delay
module ddrt_ctl import ddrt_pkg::*; (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	ddrt_if.ctl L
);
	// ************************************************************
	// Helpers
	// ************************************************************
	// Write recovery in ns to whole cycles, rounding up
	function automatic logic [7:0] ns_to_cyc(input logic [7:0] ns);
		ns_to_cyc = 8'(({1'b0, ns} + 9'h004) / 9'h005);
	endfunction

	// Count down to zero, a fresh load only ever lengthens the wait
	function automatic logic [7:0] step(input logic [7:0] c,
		input logic ld, input logic [7:0] v);
		logic [7:0] d;
		d = (c == 8'h00) ? 8'h00 : c - 8'h01;
		step = (ld && v > d) ? v : d;
	endfunction

	// ************************************************************
	// Registers and APB decode
	// ************************************************************
	logic [31:0] cfg_reg, rd_reg;
	logic pd_req_reg, odt_req_reg, dqs_req_reg, strobe_reg;
	logic pend_reg, pbc4_reg;
	ddrt_cmd_t pop_reg, cmd_reg;
	logic [15:0] paddr_reg, addr_reg;
	ddrt_pwr_t pwr_reg;
	logic cke_reg, bc4_reg, odt_reg, oe_reg, dqs_reg, due_reg;
	logic [7:0] pden_cnt, rfc_cnt, odth_cnt, wlmrd_cnt, wldqs_cnt;
	logic [7:0] xpdll_cnt;
	logic [10:0] refi_cnt;
	logic acc, wr_en, hit_cmd, hit_cfg, hit_ctrl, hit_stat, hit, busy_err;
	logic [31:0] rd_mux, stat;

	assign acc = PSEL && PENABLE;
	assign hit_cmd = PADDR == A_CMD;
	assign hit_cfg = PADDR == A_CFG;
	assign hit_ctrl = PADDR == A_CTRL;
	assign hit_stat = PADDR == A_STAT;
	assign hit = hit_cmd || hit_cfg || hit_ctrl || hit_stat;
	// A second command while one waits is refused, not queued
	assign busy_err = hit_cmd && PWRITE && pend_reg;
	assign wr_en = acc && PWRITE && hit && !busy_err;
	assign PREADY = 1'b1;
	assign PSLVERR = acc && (!hit || busy_err);
	assign PRDATA = rd_reg;

	// ************************************************************
	// Spacing decisions
	// ************************************************************
	logic [4:0] wl;
	logic [7:0] wrc, tail, pd_load, wr_odth;
	logic up, ref_go, cmd_go, pd_go, pd_exit, lvl, rise, fall;
	ddrt_cmd_t go_op;
	logic go_wr;

	assign wl = 5'({1'b0, cfg_reg[CF_CWL +: 4]} + {1'b0, cfg_reg[CF_AL +: 4]});
	assign wrc = ns_to_cyc(cfg_reg[CF_WRNS +: 8]);
	assign tail = cfg_reg[CF_BC4] ? TAIL_BC4 : TAIL_BL8;
	assign up = pwr_reg == PW_UP;
	assign ref_go = up && due_reg && cfg_reg[CF_AUTO] &&
		rfc_cnt == 8'h00;
	// Reads wait out the loop relock after a frozen exit
	assign cmd_go = up && pend_reg && !ref_go &&
		!((pop_reg == C_ACT || pop_reg == C_REF) && rfc_cnt != 8'h00) &&
		!(pop_reg == C_RD && xpdll_cnt != 8'h00);
	assign go_op = ref_go ? C_REF : (cmd_go ? pop_reg : C_NOP);
	assign go_wr = go_op == C_WR || go_op == C_WRA;
	assign lvl = cmd_go && pop_reg == C_MRS && paddr_reg[MA_LVL];
	// Power-down while the device is still busy is legal
	assign pd_go = up && pd_req_reg && pden_cnt == 8'h00 &&
		go_op == C_NOP && xpdll_cnt == 8'h00;
	assign pd_exit = !up && !pd_req_reg;
	// Power-down entry spacing per issued command
	always_comb begin
		unique case (go_op)
			C_WRA: pd_load = 8'(wl) + tail + wrc + WRA_EXTRA;
			C_WR: pd_load = 8'(wl) + tail + wrc;
			C_REF: pd_load = REFPDEN_CYC;
			C_MRS: pd_load = MOD_CYC;
			default: pd_load = 8'h00;
		endcase
	end
	assign rise = !odt_reg && odt_req_reg && xpdll_cnt == 8'h00;
	assign fall = odt_reg && !odt_req_reg && odth_cnt == 8'h00;
	assign wr_odth = (cfg_reg[CF_BC4] || pbc4_reg) ?
		ODTH_SHORT : ODTH_LONG;
	assign stat = {23'h00_0000, strobe_reg, odt_reg, wlmrd_cnt == 8'h00,
		xpdll_cnt == 8'h00, rfc_cnt == 8'h00, pden_cnt == 8'h00,
		due_reg, !cke_reg, pend_reg};
	assign rd_mux = hit_cfg ? cfg_reg : hit_ctrl ?
		{28'h000_0000, strobe_reg, dqs_req_reg, odt_req_reg, pd_req_reg} :
		hit_stat ? stat : 32'h0000_0000;

	// Software registers; the strobe request is set-wins
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			cfg_reg <= CFG_RST;
			{pd_req_reg, odt_req_reg, dqs_req_reg} <= 3'h0;
			strobe_reg <= 1'b0;
			pend_reg <= 1'b0;
			pop_reg <= C_NOP;
			pbc4_reg <= 1'b0;
			paddr_reg <= 16'h0000;
			rd_reg <= 32'h0000_0000;
		end else begin
			if (PSEL && !PENABLE)
				rd_reg <= rd_mux;
			if (wr_en && hit_cfg)
				cfg_reg <= PWDATA;
			if (wr_en && hit_ctrl)
				{dqs_req_reg, odt_req_reg, pd_req_reg} <= PWDATA[2:0];
			if (wr_en && hit_ctrl && PWDATA[3])
				strobe_reg <= 1'b1;
			else if (dqs_reg)
				strobe_reg <= 1'b0;
			if (wr_en && hit_cmd) begin
				pend_reg <= 1'b1;
				pop_reg <= ddrt_cmd_t'(PWDATA[2:0]);
				pbc4_reg <= PWDATA[3];
				paddr_reg <= PWDATA[31:16];
			end else if (cmd_go)
				pend_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Link drive and spacing counters
	// ************************************************************
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			pwr_reg <= PW_UP;
			cke_reg <= 1'b1;
			cmd_reg <= C_NOP;
			addr_reg <= 16'h0000;
			bc4_reg <= 1'b0;
			odt_reg <= 1'b0;
			oe_reg <= 1'b0;
			dqs_reg <= 1'b0;
		end else begin
			cmd_reg <= go_op;
			if (cmd_go) begin
				addr_reg <= paddr_reg;
				bc4_reg <= pbc4_reg;
			end
			if (pd_go) begin
				pwr_reg <= PW_DOWN;
				cke_reg <= 1'b0;
			end else if (pd_exit) begin
				pwr_reg <= PW_UP;
				cke_reg <= 1'b1;
			end
			if (rise)
				odt_reg <= 1'b1;
			else if (fall)
				odt_reg <= 1'b0;
			oe_reg <= dqs_req_reg && wldqs_cnt == 8'h00;
			dqs_reg <= strobe_reg && !dqs_reg && oe_reg &&
				wlmrd_cnt == 8'h00;
		end
	end

	// Power-down entry gaps share pden_cnt; xpdll_cnt holds reads, termination and power-down entry after a frozen exit
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			{pden_cnt, rfc_cnt, odth_cnt} <= 24'h00_0000;
			{wlmrd_cnt, wldqs_cnt, xpdll_cnt} <= 24'h00_0000;
			refi_cnt <= REFI_NORM_CYC;
			due_reg <= 1'b0;
		end else begin
			pden_cnt <= step(pden_cnt, 1'b1, pd_load);
			rfc_cnt <= step(rfc_cnt, go_op == C_REF, RFC_CYC);
			odth_cnt <= step(odth_cnt, rise || (go_wr && odt_reg),
				rise ? ODTH_SHORT : wr_odth);
			wlmrd_cnt <= step(wlmrd_cnt, lvl, LVL_STROBE_CYC);
			wldqs_cnt <= step(wldqs_cnt, lvl, LVL_ENABLE_CYC);
			xpdll_cnt <= step(xpdll_cnt, pd_exit && cfg_reg[CF_DLLFZ],
				XPDLL_CYC);
			// Interval counter; a due refresh set wins over its clear
			if (refi_cnt == 11'h000) begin
				refi_cnt <= cfg_reg[CF_HOT] ?
					REFI_HOT_CYC : REFI_NORM_CYC;
				due_reg <= 1'b1;
			end else begin
				refi_cnt <= refi_cnt - 11'h001;
				if (ref_go)
					due_reg <= 1'b0;
			end
		end
	end

	assign L.cke = cke_reg;
	assign L.cmd = cmd_reg;
	assign L.addr = addr_reg;
	assign L.bc4_otf = bc4_reg;
	assign L.odt = odt_reg;
	assign L.dqs_oe = oe_reg;
	assign L.dqs = dqs_reg;
endmodule // ddrt_ctl

// file: dv/ddrt_link_sva.sv
// Checker for command spacing seen on the controller to device link
`timescale 1ns/1ps
module ddrt_link_sva import ddrt_pkg::*; (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic cke,
	input wire ddrt_cmd_t cmd,
	input wire logic [15:0] addr,
	input wire logic bc4_otf,
	input wire logic odt,
	input wire logic dqs_oe,
	input wire logic dqs
);
	// ************************************************************
	// Cycles since each event, saturating so stale events stay legal
	// ************************************************************
	logic [7:0] s_ref, s_mrs, s_wr, s_lvl, s_pdx, need, hi;
	logic [15:0] mr;
	logic bl8, cke_q;
	wire go = cke && cmd != C_NOP;
	wire mrs = go && cmd == C_MRS;
	wire wr = go && (cmd == C_WR || cmd == C_WRA);
	function automatic logic [7:0] inc(logic [7:0] v);
		return (v == 8'hFF) ? v : v + 8'h01;
	endfunction
	// Mode copy mirrors the device after reset
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			{s_ref, s_mrs, s_wr, s_lvl, s_pdx} <= {5{8'hFF}};
			need <= 8'h00;
			hi <= 8'h00;
			mr <= 16'h0505;
			bl8 <= 1'b0;
			cke_q <= 1'b1;
		end else begin
			s_ref <= (go && cmd == C_REF) ? 8'h01 : inc(s_ref);
			s_mrs <= mrs ? 8'h01 : inc(s_mrs);
			s_wr <= wr ? 8'h01 : inc(s_wr);
			s_lvl <= (mrs && addr[MA_LVL]) ? 8'h01 : inc(s_lvl);
			s_pdx <= (cke && !cke_q && mr[MA_DLLFZ]) ? 8'h01 : inc(s_pdx);
			if (mrs)
				mr <= addr;
			if (wr)
				need <= mr[3:0] + mr[7:4] + mr[11:8] +
					(mr[MA_BC4] ? TAIL_BC4 : TAIL_BL8) +
					((cmd == C_WRA) ? WRA_EXTRA : 8'h00);
			hi <= odt ? inc(hi) : 8'h00;
			bl8 <= odt && (bl8 || (wr && !bc4_otf && !mr[MA_BC4]));
			cke_q <= cke;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_ref_spacing: assert property (
		go && (cmd == C_ACT || cmd == C_REF) |-> s_ref >= RFC_CYC)
		else $error("Refresh followed too soon");
	a_ref_pd_gap: assert property (
		$fell(cke) |-> s_ref >= REFPDEN_CYC)
		else $error("Power-down too soon after refresh");
	a_mrs_pd_gap: assert property (
		$fell(cke) |-> s_mrs >= MOD_CYC)
		else $error("Power-down too soon after mode set");
	a_write_pd_gap: assert property (
		$fell(cke) |-> s_wr >= need)
		else $error("Power-down too soon after write");
	a_odt_short: assert property (
		$rose(odt) |=> odt [*3])
		else $error("Termination request too short");
	a_odt_long: assert property (
		$fell(odt) |-> hi >= (bl8 ? ODTH_LONG : ODTH_SHORT))
		else $error("Termination request short for long write");
	a_lvl_enable: assert property (
		$rose(dqs_oe) |-> s_lvl >= LVL_ENABLE_CYC)
		else $error("Strobe driver enabled too soon");
	a_lvl_strobe: assert property (
		dqs |-> s_lvl >= LVL_STROBE_CYC ##1 !dqs)
		else $error("Strobe pulse too soon or too long");
	a_relock_wait: assert property (
		(go && cmd == C_RD) || $rose(odt) |-> s_pdx >= XPDLL_CYC)
		else $error("Loop dependent command too soon after exit");
endmodule // ddrt_link_sva

// file: dv/ddrt_cmd_timing_rules_bench.sv
// Testbench joining controller and device ends over the link
`timescale 1ns/1ps
module ddrt_cmd_timing_rules_bench import ddrt_pkg::*;;
	localparam logic [33:0] NO = 34'h0_0000_0000;
	logic clk, nrst, psel, pen, pwr, fc, prdy, perr;
	logic term_nom, term_wr, wr_start, pd_idle, odt_p, term_p, armed;
	logic [7:0] padr;
	logic [3:0] cw, al, wrc;
	logic [31:0] pwd, prd, rd, x, cfg, seed;
	logic [33:0] n;
	int miscompares, check_count, cyc, odt_cyc, wl;
	logic [33:0] rd_q[$];
	int lat_q[$], trm_q[$], wc_q[$];
	ddrt_if u_ddrt_if();
	ddrt_ctl u_ddrt_ctl(.CLK(clk), .NRST(nrst), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
		.PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .L(u_ddrt_if));
	ddrt_dev u_ddrt_dev(.CLK(clk), .NRST(nrst), .L(u_ddrt_if),
		.TERM_NOM(term_nom), .TERM_WR(term_wr), .WR_START(wr_start),
		.PD_IDLE(pd_idle));
	ddrt_link_sva u_ddrt_link_sva(.CLK(clk), .NRST(nrst),
		.cke(u_ddrt_if.cke), .cmd(u_ddrt_if.cmd), .addr(u_ddrt_if.addr),
		.bc4_otf(u_ddrt_if.bc4_otf), .odt(u_ddrt_if.odt),
		.dqs_oe(u_ddrt_if.dqs_oe), .dqs(u_ddrt_if.dqs));
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(string s, logic [31:0] v, logic [31:0] e);
		check_count++;
		if (v !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h seen %h", s, e, v);
		end
	endtask
	task automatic summarize();
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Note: bit 33 asks for a check, bit 32 is the expected error
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
		logic [33:0] e);
		rd_q.push_back(e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rd = prd;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Polling waits out the one command in flight
	task automatic issue(logic [2:0] op, logic otf, logic [15:0] a);
		apb(1'b1, A_CMD, {a, 12'h000, otf, op}, NO);
		for (int i = 0; i < 300; i++) begin
			apb(1'b0, A_STAT, 32'h0000_0000, NO);
			if (rd[0] === 1'b0)
				break;
		end
		// A command that never leaves counts against the run
		if (rd[0] !== 1'b0)
			miscompares++;
	endtask
	task automatic wcke(logic v);
		for (int i = 0; i < 400; i++) begin
			@(posedge clk);
			if (u_ddrt_if.cke === v)
				break;
		end
		if (u_ddrt_if.cke !== v)
			miscompares++;
	endtask
	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Watchdog cuts a hang short
	initial begin
		#100000;
		miscompares++;
		summarize();
	end
	// Monitor: sampled values before each edge, oldest note first
	always @(posedge clk) begin
		cyc++;
		if (psel && pen && prdy) begin
			n = rd_q.pop_front();
			if (n[33])
				check("pslverr", 32'(perr), 32'(n[32]));
			if (n[33] && !pwr)
				check("prdata", prd, n[31:0]);
		end
		if (u_ddrt_if.cke && u_ddrt_if.cmd inside {C_WR, C_WRA})
			wc_q.push_back(cyc);
		if (wr_start)
			check("wr_start", cyc - wc_q.pop_front(),
				lat_q.pop_front());
		// Write termination replaces nominal, never both at once
		if (term_wr)
			check("term_both", 32'(term_nom), 32'h0000_0000);
		if (u_ddrt_if.odt && !odt_p) begin
			odt_cyc = cyc;
			armed = 1'b1;
		end
		if (term_nom && !term_p && armed) begin
			armed = 1'b0;
			check("term_nom", cyc - odt_cyc, trm_q.pop_front());
		end
		odt_p = u_ddrt_if.odt;
		term_p = term_nom;
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{nrst, psel, pen, pwr, odt_p, term_p, armed} = 7'h00;
		padr = 8'h00;
		pwd = 32'h0000_0000;
		seed = 32'h0001_8415;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, A_CFG, 32'h0000_0000, {2'b10, CFG_RST});
		apb(1'b0, 8'h10, 32'h0000_0000, {2'b11, 32'h0000_0000});
		apb(1'b1, 8'h14, 32'hFFFF_FFFF, {2'b11, 32'h0000_0000});
		// Random latencies; last pass fixes chop in the mode
		for (int i = 0; i < 3; i++) begin
			x = rnd();
			cw = 4'h5 + x[1:0];
			al = {3'h0, x[2]};
			wrc = 4'h5 + x[4:3];
			fc = (i == 2);
			wl = cw + al;
			cfg = {15'h0000, fc, 8'(wrc) * 8'h05, al, cw};
			apb(1'b1, A_CFG, cfg, NO);
			apb(1'b0, A_CFG, 32'h0000_0000, {2'b10, cfg});
			issue(C_MRS, 1'b0, {3'h0, fc, wrc, al, cw});
			trm_q.push_back(wl - 2 + 1);
			apb(1'b1, A_CTRL, 32'h0000_0002, NO);
			lat_q.push_back(wl + (fc ? 2 : 4) + 1);
			issue(C_WR, x[5], 16'h0000);
			lat_q.push_back(wl + (fc ? 2 : 4) + 1);
			issue(C_WRA, x[6], 16'h0000);
			apb(1'b1, A_CTRL, 32'h0000_0001, NO);
			wcke(1'b0);
			apb(1'b1, A_CTRL, 32'h0000_0000, NO);
			wcke(1'b1);
		end
		// Refresh then activate; a command while one waits is refused
		apb(1'b1, A_CMD, {29'h0000_0000, C_REF}, NO);
		apb(1'b1, A_CMD, {29'h0000_0000, C_ACT}, NO);
		apb(1'b1, A_CMD, {29'h0000_0000, C_PRE}, {2'b11, 32'h0000_0000});
		// Let the held activate leave so the refresh is not refused
		repeat (40) @(posedge clk);
		issue(C_REF, 1'b0, 16'h0000);
		apb(1'b1, A_CTRL, 32'h0000_0001, NO);
		wcke(1'b0);
		#1;
		check("pd_idle", 32'(pd_idle), 32'h0000_0000);
		repeat (40) @(posedge clk);
		#1;
		check("pd_idle", 32'(pd_idle), 32'h0000_0001);
		apb(1'b1, A_CTRL, 32'h0000_0000, NO);
		wcke(1'b1);
		// Leveling: strobe driver asked for first, then driver and pulse together
		issue(C_MRS, 1'b0, {3'h1, fc, wrc, al, cw});
		apb(1'b1, A_CTRL, 32'h0000_0004, NO);
		apb(1'b1, A_CTRL, 32'h0000_000C, NO);
		repeat (60) @(posedge clk);
		// Strobe pulse must have gone out by now
		apb(1'b0, A_CTRL, 32'h0000_0000, {2'b10, 32'h0000_0004});
		apb(1'b1, A_CTRL, 32'h0000_0000, NO);
		// Frozen loop: mode set then power-down, read right after exit
		apb(1'b1, A_CFG, cfg | 32'h0004_0000, NO);
		issue(C_MRS, 1'b0, {3'h2, fc, wrc, al, cw});
		apb(1'b1, A_CTRL, 32'h0000_0001, NO);
		wcke(1'b0);
		apb(1'b1, A_CTRL, 32'h0000_0000, NO);
		wcke(1'b1);
		trm_q.push_back(wl - 2 + 1);
		apb(1'b1, A_CTRL, 32'h0000_0002, NO);
		issue(C_RD, 1'b0, 16'h0000);
		repeat (40) @(posedge clk);
		apb(1'b1, A_CTRL, 32'h0000_0000, NO);
		repeat (20) @(posedge clk);
		summarize();
	end
endmodule // ddrt_cmd_timing_rules_bench
